// ==== dkrc_cfg.svh ====
// constants for the disk rate configuration and result status block
`ifndef DKRC_CFG_SVH
`define DKRC_CFG_SVH
`define DKRC_ADDR_W          3
`define DKRC_OFS_RATE_CFG    3'h7
`define DKRC_OFS_DATA        3'h5
`define DKRC_RATE_RST        2'h2
`define DKRC_NOPREC_RST      1'h0
`define DKRC_RATE_LSB        0
`define DKRC_NOPREC_BIT      2
`define DKRC_CC_NORMAL       2'h0
`define DKRC_CC_ABNORMAL     2'h1
`define DKRC_CC_INVALID      2'h2
`define DKRC_CC_POLLING      2'h3
`define DKRC_RECAL_STEPS     7'h50
`define DKRC_LAST_SECTOR     8'hFF
`define DKRC_INDEX_LIMIT     2'h2
`endif

// ==== dkrc_pkg.sv ====
// types for the disk rate configuration and result status block
package dkrc_pkg;
   typedef enum logic [1:0] {
      DKRC_MODE_AT   = 2'h0,
      DKRC_MODE_PS2  = 2'h1,
      DKRC_MODE_M30  = 2'h2
   } dkrc_mode_e;
   typedef enum logic [2:0] {
      DKRC_ST_CMD  = 3'b001,
      DKRC_ST_EXEC = 3'b010,
      DKRC_ST_RES  = 3'b100
   } dkrc_state_e;
endpackage

// ==== dkrc_flags.sv ====
// sticky status flag bank, one generate entry per flag
`timescale 1ns/100ps
`default_nettype none
module dkrc_flags #(
   parameter int N = 8
) (
   // clock and control
   input  wire logic         i_clk,
   input  wire logic         i_ce,
   input  wire logic         i_rst_b,
   input  wire logic         i_clr,
   // events
   input  wire logic [N-1:0] i_set,
   // held flags
   output logic      [N-1:0] o_flag
);
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_flag
         // set wins over clear
         wire next_flag = i_set[g] | (o_flag[g] & ~i_clr);
         always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
               o_flag[g] <= 1'b0;
            end else if (i_ce) begin
               o_flag[g] <= next_flag;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== dkrc_top.sv ====
// disk rate configuration register and result status byte encoder
`timescale 1ns/100ps
`default_nettype none
`include "dkrc_cfg.svh"
module dkrc_top (
   // clock, enable, resets
   input  wire logic                    I_CLK,
   input  wire logic                    I_CE,
   input  wire logic                    I_RST_B,
   input  wire logic                    I_SW_RST,
   // host register access
   input  wire logic [`DKRC_ADDR_W-1:0] I_ADDR,
   input  wire logic                    I_WR,
   input  wire logic                    I_RD,
   input  wire logic [7:0]              I_WDATA,
   output logic      [7:0]              O_RDATA,
   // interface mode and digital input sources
   input  wire logic [1:0]              I_MODE,
   input  wire logic                    I_DISK_CHANGE,
   input  wire logic                    I_DMA_EN,
   // command sequencing
   input  wire logic                    I_CMD_START,
   input  wire logic                    I_CMD_END,
   input  wire logic [1:0]              I_COMPLETION,
   input  wire logic                    I_HEAD,
   input  wire logic [1:0]              I_DRIVE_SEL,
   // drive and data events
   input  wire logic                    I_SEEK_DONE,
   input  wire logic                    I_STEP,
   input  wire logic                    I_IS_RECAL,
   input  wire logic                    I_OUTWARD_OVERSTEP,
   input  wire logic                    I_TRACK_ZERO_IN,
   input  wire logic                    I_INDEX_PULSE_IN,
   input  wire logic                    I_ID_SEARCH,
   input  wire logic                    I_ID_MARK_FOUND,
   input  wire logic                    I_DATA_MARK_MISS,
   input  wire logic [7:0]              I_SECTOR,
   input  wire logic                    I_SECTOR_ACCESS,
   input  wire logic                    I_NO_TC_END,
   input  wire logic                    I_CRC_FAULT,
   input  wire logic                    I_OVERRUN,
   input  wire logic                    I_SECTOR_NOT_FOUND,
   input  wire logic                    I_WRITE_OP,
   input  wire logic                    I_WRITE_PROTECT,
   // rate outputs and result status
   output logic      [1:0]              O_RATE_SEL,
   output logic                         O_NO_PRECOMP,
   output logic                         O_RESULT_PHASE
);
   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire hit_cfg    = (I_ADDR == `DKRC_OFS_RATE_CFG);
   wire hit_data   = (I_ADDR == `DKRC_OFS_DATA);
   wire wr_cfg     = I_CE & I_WR & hit_cfg;
   wire mode_m30   = (I_MODE == dkrc_pkg::DKRC_MODE_M30);
   wire mode_ps2   = (I_MODE == dkrc_pkg::DKRC_MODE_PS2);

   // ----------------------------------------------------------------
   // rate configuration register
   // ----------------------------------------------------------------
   logic [1:0] rate_config_reg;
   logic       no_precomp;
   // only hardware reset touches these; software reset is ignored here
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         rate_config_reg <= `DKRC_RATE_RST;
         no_precomp      <= `DKRC_NOPREC_RST;
      end else if (wr_cfg) begin
         rate_config_reg <= I_WDATA[`DKRC_RATE_LSB +: 2];
         if (mode_m30) begin
            no_precomp <= I_WDATA[`DKRC_NOPREC_BIT];
         end
      end
   end
   assign O_RATE_SEL   = rate_config_reg;
   assign O_NO_PRECOMP = no_precomp;

   // ----------------------------------------------------------------
   // digital input register image at offset 7
   // ----------------------------------------------------------------
   wire rate_select_lo = rate_config_reg[0];
   wire rate_select_hi = rate_config_reg[1];
   wire high_dens_b    = ~(rate_config_reg == 2'h0 || rate_config_reg == 2'h3);
   wire [7:0] dir_at   = {I_DISK_CHANGE, 7'h00};
   wire [7:0] dir_ps2  = {I_DISK_CHANGE, 4'hF, rate_select_hi, rate_select_lo, high_dens_b};
   wire [7:0] dir_m30  = {I_DISK_CHANGE, 3'h0, I_DMA_EN, no_precomp,
                          rate_select_hi, rate_select_lo};
   wire [7:0] dir_val  = mode_m30 ? dir_m30 : (mode_ps2 ? dir_ps2 : dir_at);

   // ----------------------------------------------------------------
   // command phase tracking
   // ----------------------------------------------------------------
   dkrc_pkg::dkrc_state_e state;
   dkrc_pkg::dkrc_state_e next_state;
   logic                  byte_idx;
   wire rd_data   = I_CE & I_RD & hit_data;
   wire in_exec   = (state == dkrc_pkg::DKRC_ST_EXEC);
   wire in_res    = (state == dkrc_pkg::DKRC_ST_RES);
   wire rd_st1    = in_res & rd_data & byte_idx;
   wire rd_st0    = in_res & rd_data & ~byte_idx;

   always_comb begin
      case (state)
         dkrc_pkg::DKRC_ST_CMD:  next_state = I_CMD_START ? dkrc_pkg::DKRC_ST_EXEC : state;
         dkrc_pkg::DKRC_ST_EXEC: next_state = I_CMD_END ? dkrc_pkg::DKRC_ST_RES : state;
         dkrc_pkg::DKRC_ST_RES:  next_state = rd_st1 ? dkrc_pkg::DKRC_ST_CMD : state;
         default:                next_state = dkrc_pkg::DKRC_ST_CMD;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B || I_SW_RST) begin
         state    <= dkrc_pkg::DKRC_ST_CMD;
         byte_idx <= 1'b0;
      end else if (I_CE) begin
         state <= next_state;
         if (rd_st0) begin
            byte_idx <= 1'b1;
         end else if (rd_st1 || !in_res) begin
            byte_idx <= 1'b0;
         end
      end
   end
   assign O_RESULT_PHASE = in_res;

   // ----------------------------------------------------------------
   // event detection during execution
   // ----------------------------------------------------------------
   logic [6:0] step_cnt;
   logic [1:0] index_cnt;
   logic [1:0] completion;
   logic       head;
   logic [1:0] drive_sel;
   wire recal_fail  = I_IS_RECAL & I_STEP & ~I_TRACK_ZERO_IN
                      & (step_cnt == `DKRC_RECAL_STEPS - 7'h01);
   wire idx_fail    = I_ID_SEARCH & I_INDEX_PULSE_IN & ~I_ID_MARK_FOUND
                      & (index_cnt == `DKRC_INDEX_LIMIT - 2'h1);
   wire sector_over = I_SECTOR_ACCESS & (I_SECTOR == `DKRC_LAST_SECTOR);

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B || I_SW_RST) begin
         step_cnt   <= 7'h00;
         index_cnt  <= 2'h0;
         completion <= `DKRC_CC_NORMAL;
         head       <= 1'b0;
         drive_sel  <= 2'h0;
      end else if (I_CE) begin
         if (I_CMD_START) begin
            step_cnt  <= 7'h00;
            index_cnt <= 2'h0;
         end else if (in_exec) begin
            if (I_IS_RECAL && I_STEP && step_cnt != `DKRC_RECAL_STEPS) begin
               step_cnt <= step_cnt + 7'h01;
            end
            if (I_ID_SEARCH && I_INDEX_PULSE_IN && index_cnt != `DKRC_INDEX_LIMIT) begin
               index_cnt <= index_cnt + 2'h1;
            end
         end
         if (in_exec && I_CMD_END) begin
            completion <= I_COMPLETION;
            head       <= I_HEAD;
            drive_sel  <= I_DRIVE_SEL;
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky flags, cleared once their byte is read
   // ----------------------------------------------------------------
   logic [2:0] st0_flag;
   logic [5:0] st1_flag;
   wire  [2:0] st0_set = {3{in_exec}} & {
      I_SEEK_DONE,
      recal_fail | I_OUTWARD_OVERSTEP,
      1'b0};
   wire  [5:0] st1_set = {6{in_exec}} & {
      sector_over | (I_CMD_END & I_NO_TC_END),
      I_CRC_FAULT,
      I_OVERRUN,
      I_SECTOR_NOT_FOUND,
      I_WRITE_OP & I_WRITE_PROTECT,
      idx_fail | I_DATA_MARK_MISS};

   dkrc_flags #(.N(3)) u_st0 (
      .i_clk   (I_CLK),
      .i_ce    (I_CE),
      .i_rst_b (I_RST_B & ~I_SW_RST),
      .i_clr   (rd_st0),
      .i_set   (st0_set),
      .o_flag  (st0_flag)
   );
   dkrc_flags #(.N(6)) u_st1 (
      .i_clk   (I_CLK),
      .i_ce    (I_CE),
      .i_rst_b (I_RST_B & ~I_SW_RST),
      .i_clr   (rd_st1),
      .i_set   (st1_set),
      .o_flag  (st1_flag)
   );

   // ----------------------------------------------------------------
   // status byte encoding and read mux
   // ----------------------------------------------------------------
   wire [7:0] status0 = {completion, st0_flag[2], st0_flag[1],
                         1'b0, head, drive_sel};
   wire [7:0] status1 = {st1_flag[5], 1'b0, st1_flag[4], st1_flag[3],
                         1'b0, st1_flag[2], st1_flag[1], st1_flag[0]};
   wire [7:0] data_val = byte_idx ? status1 : status0;
   wire [7:0] next_rdata = (I_RD && hit_cfg) ? dir_val :
                           (I_RD && hit_data && in_res) ? data_val : 8'h00;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         O_RDATA <= 8'h00;
      end else if (I_CE) begin
         O_RDATA <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ==== dkrc_top_props.sv ====
// checker for the rate register, input image and result phase ports
`timescale 1ns/100ps
`default_nettype none
`include "dkrc_cfg.svh"
module dkrc_chk (
   // clock, reset and strobes
   input wire logic                    I_CLK,
   input wire logic                    I_CE,
   input wire logic                    I_RST_B,
   input wire logic                    I_WR,
   input wire logic                    I_RD,
   input wire logic                    I_CMD_END,
   input wire logic                    I_DMA_EN,
   // buses
   input wire logic [`DKRC_ADDR_W-1:0] I_ADDR,
   input wire logic [7:0]              I_WDATA,
   input wire logic [1:0]              I_MODE,
   input wire logic [7:0]              O_RDATA,
   input wire logic [1:0]              O_RATE_SEL,
   input wire logic                    O_NO_PRECOMP,
   input wire logic                    O_RESULT_PHASE
);
   wire wr7 = I_CE & I_WR & (I_ADDR == 3'h7);
   wire rd7 = I_CE & I_RD & (I_ADDR == 3'h7);
   wire m30 = (I_MODE == 2'h2);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);
   a_rate_reset: assert property (disable iff (1'b0) !I_RST_B |=> O_RATE_SEL == 2'h2 && !O_NO_PRECOMP)
      else $error("rate register not at reset value");
   a_rate_write: assert property (wr7 |=> O_RATE_SEL == $past(I_WDATA[1:0]))
      else $error("rate select not taken from write");
   a_noprec_write: assert property (wr7 && m30 |=> O_NO_PRECOMP == $past(I_WDATA[2]))
      else $error("no precomp flag not taken from write");
   a_noprec_hold: assert property (!(wr7 && m30) |=> $stable(O_NO_PRECOMP))
      else $error("no precomp flag changed without a third mode write");
   a_rate_hold: assert property (!wr7 |=> $stable(O_RATE_SEL))
      else $error("rate select changed without a write");
   a_rdata_idle: assert property (I_CE && !I_RD |=> O_RDATA == 8'h00)
      else $error("read data not zero without a read");
   a_dir_mirror: assert property (rd7 && m30 |=> O_RDATA[6:0] ==
      {3'h0, $past(I_DMA_EN), $past(O_NO_PRECOMP), $past(O_RATE_SEL)})
      else $error("input image bits wrong in third mode");
   a_unused_zero: assert property (O_RESULT_PHASE && I_CE && I_RD && I_ADDR == 3'h5
      |=> O_RDATA[3] == 1'b0)
      else $error("unused status bit set");
   a_result_entry: assert property ($rose(O_RESULT_PHASE) |-> $past(I_CMD_END))
      else $error("result phase entered without command end");
endmodule
bind dkrc_top dkrc_chk u_chk (.I_CLK, .I_CE, .I_RST_B, .I_WR, .I_RD, .I_CMD_END, .I_DMA_EN,
   .I_ADDR, .I_WDATA, .I_MODE, .O_RDATA, .O_RATE_SEL, .O_NO_PRECOMP, .O_RESULT_PHASE);
`default_nettype wire

// ==== dkrc_host.sv ====
// host processor model: register writes and reads
`timescale 1ns/100ps
`default_nettype none
`include "dkrc_cfg.svh"
module dkrc_host (
   // clock
   input  wire logic                    i_clk,
   // controller bus
   output logic      [`DKRC_ADDR_W-1:0] o_addr = 3'h0,
   output logic                         o_wr = 1'b0,
   output logic                         o_rd = 1'b0,
   output logic      [7:0]              o_wdata = 8'h00,
   input  wire logic [7:0]              i_rdata
);
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #5 o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #5 o_wr = 1'b0;
      o_wdata = ~d;
      o_addr = ~a;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #5 o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #5 o_rd = 1'b0;
      o_addr = ~a;
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// ==== test_disk_rate_config_and_result_status.sv ====
// testbench for rate register and result status bytes
`timescale 1ns/100ps
`default_nettype none
module test_disk_rate_config_and_result_status;
   logic       clk = 0, rst_b = 0, sw_rst = 0, dma_en = 0, cmd_start = 0, cmd_end = 0;
   logic       head = 0, recal = 0, step = 0, index_p = 0, id_search = 0, sec_acc = 0;
   logic       no_tc = 0, ce = 1;
   logic [1:0] mode = 0, cc = 0, ds = 0, rsel;
   logic [5:0] ev = 0;
   logic [7:0] sector = 0, rdata, wdata, d;
   logic [2:0] addr;
   logic       wr, rd, res, nprec;
   int         err_count = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   dkrc_host u_host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
      .i_rdata(rdata));
   dkrc_top uut (.I_CLK(clk), .I_CE(ce), .I_RST_B(rst_b), .I_SW_RST(sw_rst), .I_ADDR(addr),
      .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_MODE(mode),
      .I_DISK_CHANGE(1'b0), .I_DMA_EN(dma_en), .I_CMD_START(cmd_start), .I_CMD_END(cmd_end),
      .I_COMPLETION(cc), .I_HEAD(head), .I_DRIVE_SEL(ds), .I_SEEK_DONE(ev[0]), .I_STEP(step),
      .I_IS_RECAL(recal), .I_OUTWARD_OVERSTEP(ev[1]), .I_TRACK_ZERO_IN(1'b0),
      .I_INDEX_PULSE_IN(index_p), .I_ID_SEARCH(id_search), .I_ID_MARK_FOUND(1'b0),
      .I_DATA_MARK_MISS(1'b0), .I_SECTOR(sector), .I_SECTOR_ACCESS(sec_acc),
      .I_NO_TC_END(no_tc), .I_CRC_FAULT(ev[2]), .I_OVERRUN(ev[3]), .I_SECTOR_NOT_FOUND(ev[4]),
      .I_WRITE_OP(ev[5]), .I_WRITE_PROTECT(ev[5]), .O_RATE_SEL(rsel), .O_NO_PRECOMP(nprec),
      .O_RESULT_PHASE(res));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %0t got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk);
      #5 s = 1'b1;
      @(posedge clk);
      #5 s = 1'b0;
   endtask
   task automatic t_rate;
      mode = 2'h2;
      u_host.rd(3'h7, d);
      chk({1'b0, d[6:0]}, 8'h02);
      mode = 2'h0;
      u_host.wr(3'h7, 8'hFF);
      chk({5'h0, nprec, rsel}, 8'h03);
      mode = 2'h1;
      u_host.rd(3'h7, d);
      chk({1'b0, d[6:0]}, 8'h7E);
      mode = 2'h2;
      dma_en = 1'b1;
      u_host.wr(3'h7, 8'hFD);
      chk({5'h0, nprec, rsel}, 8'h05);
      u_host.rd(3'h7, d);
      chk({1'b0, d[6:0]}, 8'h0D);
      u_host.rd(3'h3, d);
      chk(d, 8'h00);
      u_host.rd(3'h5, d);
      chk(d, 8'h00);
      ce = 1'b0;
      u_host.wr(3'h7, 8'h00);
      chk({5'h0, nprec, rsel}, 8'h05);
      ce = 1'b1;
      pulse(sw_rst);
      chk({5'h0, nprec, rsel}, 8'h05);
      @(posedge clk);
      #5 rst_b = 1'b0;
      @(posedge clk);
      #5 rst_b = 1'b1;
      chk({5'h0, nprec, rsel}, 8'h02);
   endtask
   task automatic t_cmd(input logic [1:0] c, input logic h, input logic [1:0] dv,
                        input logic [7:0] e, input int n);
      pulse(cmd_start);
      ev = e[5:0];
      recal = (n > 0);
      id_search = e[6];
      sec_acc = 1'b1;
      sector = (e[7] & !c[0]) ? 8'hFF : 8'h03;
      @(posedge clk);
      #5 ev = 6'h00;
      sec_acc = 1'b0;
      repeat (n) pulse(step);
      if (e[6]) repeat (2) pulse(index_p);
      id_search = 1'b0;
      recal = 1'b0;
      cc = c;
      head = h;
      ds = dv;
      no_tc = e[7] & c[0];
      pulse(cmd_end);
      no_tc = 1'b0;
      cc = ~c;
      chk({7'h0, res}, 8'h01);
      u_host.rd(3'h5, d);
      chk(d, {c, e[0], e[1] | (n >= 80), 1'b0, h, dv});
      u_host.rd(3'h5, d);
      chk(d, {e[7], 1'b0, e[2], e[3], 1'b0, e[4], e[5], e[6]});
      @(posedge clk);
      #5 chk({7'h0, res}, 8'h00);
   endtask
   task automatic print_verdict;
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         print_verdict;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      #5 rst_b = 1'b1;
      t_rate;
      t_cmd(2'h0, 1'b0, 2'h0, 8'h00, 0);
      t_cmd(2'h1, 1'b1, 2'h3, 8'h96, 0);
      t_cmd(2'h2, 1'b0, 2'h1, 8'hE9, 0);
      t_cmd(2'h3, 1'b1, 2'h2, 8'h00, 80);
      t_cmd(2'h0, 1'b0, 2'h1, 8'h00, 79);
      print_verdict;
   end
endmodule
`default_nettype wire
